// ---- sim/rssa_alu_checker.sv ----
/*
  checker for the rotate/subtract/sleep alu, bound to its top module.
  assumes requests come only once the synchronised reset has settled.
*/
`timescale 1ns/1ps
module rssa_alu_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // request
  input wire logic i_valid,
  input wire rssa_pkg::rssa_req_t i_req,
  // results
  input wire rssa_pkg::rssa_wb_t o_wb,
  input wire logic [7:0] o_acc,
  input wire rssa_pkg::rssa_flags_t o_flags,
  input wire logic o_powerdown_status_bit,
  input wire logic o_timeout_status_bit,
  input wire logic o_wdt_clear,
  input wire logic [7:0] o_watchdog_counter_load,
  input wire logic [7:0] o_wdt_prescaler_load,
  input wire logic o_osc_stop,
  input wire logic o_halted
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // taken requests only: one offered while halted is dropped
  logic go, rot, lit, sf, sfb, slp;
  assign go = i_valid && !o_halted;
  assign rot = go && i_req.op == rssa_pkg::RSSA_OP_ROT_RIGHT;
  assign lit = go && i_req.op == rssa_pkg::RSSA_OP_SUB_LIT;
  assign sf = go && i_req.op == rssa_pkg::RSSA_OP_SUB_FILE;
  assign sfb = go && i_req.op == rssa_pkg::RSSA_OP_SUB_FILE_B;
  assign slp = go && i_req.op == rssa_pkg::RSSA_OP_SLEEP;
  // every result is due one cycle after its take
  rotate_path_a: assert property (rot |=> o_flags.carry == $past(i_req.file_data[0])
    && o_wb.result == {$past(o_flags.carry), $past(i_req.file_data[7:1])} && $stable(o_flags.zero))
    else $error("rotate wrong");
  dest_route_a: assert property ((rot || sf || sfb) |=>
    o_wb.file_we == $past(i_req.dest_file) && o_wb.acc_we == !$past(i_req.dest_file))
    else $error("routing wrong");
  literal_sub_a: assert property (lit |=> o_acc == $past(i_req.literal - o_acc)
    && o_flags.carry == $past(o_acc <= i_req.literal)
    && o_flags.digit_carry_flag == $past(o_acc[3:0] <= i_req.literal[3:0]))
    else $error("literal subtract wrong");
  file_sub_a: assert property (sf |=> o_wb.result == $past(i_req.file_data - o_acc)
    && o_flags.carry == $past(o_acc <= i_req.file_data) && o_flags.zero == (o_wb.result == 8'h00)
    && o_flags.digit_carry_flag == $past(o_acc[3:0] <= i_req.file_data[3:0]))
    else $error("file subtract wrong");
  borrow_sub_a: assert property (sfb |=>
    o_wb.result == $past(i_req.file_data - o_acc - {7'h00, !o_flags.carry}))
    else $error("borrow subtract wrong");
  sleep_status_a: assert property (slp |=> !o_powerdown_status_bit && o_timeout_status_bit)
    else $error("sleep status wrong");
  watchdog_clear_a: assert property (slp |=> (o_wdt_clear && o_watchdog_counter_load == 8'h00
    && o_wdt_prescaler_load == 8'h00) ##1 !o_wdt_clear)
    else $error("watchdog clear wrong");
  sleep_halt_a: assert property (slp |=> o_osc_stop && o_halted)
    else $error("sleep did not halt");
endmodule : rssa_alu_checker

// ---- sim/rssa_core_model.sv ----
/*
  file register model of the core: supplies the operand, takes write-back.
  assumes the alu write-back port drives i_wb.
*/
`timescale 1ns/1ps
module rssa_core_model (
  // clock
  input wire logic i_core_clk,
  // operand and write-back
  input wire logic [6:0] i_addr,
  input wire rssa_pkg::rssa_wb_t i_wb,
  output logic [7:0] o_data
);
  logic [7:0] mem [128];
  // operand is ready at once, as decode has fetched it already
  assign o_data = mem[i_addr];
  // plain always, so the bench may preload cells between writes
  always @(posedge i_core_clk) begin
    if (i_wb.file_we) begin
      mem[i_wb.file_addr] <= i_wb.result;
    end
  end
endmodule : rssa_core_model

// ---- sim/tb_rotate_subtract_sleep_alu.sv ----
/*
  bench for the rotate/subtract/sleep alu: instructions, registers, sleep, wake.
  assumes the core model supplies file operands; the checker is bound below.
*/
`timescale 1ns/1ps
module tb_rotate_subtract_sleep_alu;
  logic i_core_clk = 1'b0;
  logic i_rst_b, i_valid, i_wake, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, req_dst;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wdt_clear, o_osc_stop, o_halted;
  logic o_powerdown_status_bit, o_timeout_status_bit;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [3:0] i_wstrb = 4'hf;
  logic [6:0] req_fa;
  logic [7:0] o_acc, o_watchdog_counter_load, o_wdt_prescaler_load, req_lit, file_rd;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, rd;
  rssa_pkg::rssa_op_t req_op;
  rssa_pkg::rssa_req_t i_req;
  rssa_pkg::rssa_wb_t o_wb;
  rssa_pkg::rssa_flags_t o_flags;
  int error_cnt = 0;
  int tests_run = 0;
  // the file operand comes from the core model, as decode would fetch it
  assign i_req = '{req_op, req_fa, req_dst, req_lit, file_rd};
  rssa_alu dut (
    .i_core_clk, .i_rst_b, .i_valid, .i_req, .i_wake, .o_wb, .o_acc, .o_flags,
    .o_powerdown_status_bit, .o_timeout_status_bit, .o_wdt_clear, .o_watchdog_counter_load,
    .o_wdt_prescaler_load, .o_osc_stop, .o_halted, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready
  );
  rssa_core_model fm (.i_core_clk, .i_addr(req_fa), .i_wb(o_wb), .o_data(file_rd));
  // instruction clock
  always #5 i_core_clk = ~i_core_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // one bus transfer; ready is registered, so its value late in the cycle holds at the edge
  task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic [1:0] resp);
    int n;
    logic sa, sw, sr, done;
    n = 0;
    done = 1'b0;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_araddr <= a;
    i_wdata <= d;
    i_awvalid <= wr;
    i_wvalid <= wr;
    i_bready <= wr;
    i_arvalid <= !wr;
    i_rready <= !wr;
    while (!done && n < 50) begin
      @(negedge i_core_clk);
      n++;
      sa = i_awvalid & o_awready;
      sw = i_wvalid & o_wready;
      sr = i_arvalid & o_arready;
      done = (i_bready & o_bvalid) | (i_rready & o_rvalid);
      rdat = o_rdata;
      resp = wr ? o_bresp : o_rresp;
      @(posedge i_core_clk);
      if (sa) i_awvalid <= 1'b0;
      if (sw) i_wvalid <= 1'b0;
      if (sr) i_arvalid <= 1'b0;
      if (done) i_bready <= 1'b0;
      if (done) i_rready <= 1'b0;
    end
    if (!done) begin
      error_cnt++;
      $display("MISMATCH bus answer expected response seen none");
      final_report();
    end
  endtask : axi
  // offer one instruction at the next edge; valid stays up for back to back use
  task automatic put(input rssa_pkg::rssa_op_t op, input logic [6:0] fa, input logic dst,
                     input logic [7:0] k);
    @(posedge i_core_clk);
    req_op <= op;
    req_fa <= fa;
    req_dst <= dst;
    req_lit <= k;
    i_valid <= 1'b1;
  endtask : put
  task automatic idle;
    @(posedge i_core_clk);
    i_valid <= 1'b0;
    #1;
  endtask : idle
  task automatic t_regs;
    axi(1'b0, rssa_pkg::RSSA_ADDR_STATUS, 32'h0, rd, rs);
    chk("status", 32'h0000_0018, rd);
    axi(1'b1, rssa_pkg::RSSA_ADDR_ACC, 32'h0000_00a7, rd, rs);
    chk("wresp", {30'h0, rssa_pkg::RSSA_RESP_OK}, {30'h0, rs});
    axi(1'b1, 32'h0000_0010, 32'h0000_0055, rd, rs);
    chk("wresp bad", {30'h0, rssa_pkg::RSSA_RESP_ERR}, {30'h0, rs});
    axi(1'b0, rssa_pkg::RSSA_ADDR_ACC, 32'h0, rd, rs);
    chk("acc", 32'h0000_00a7, rd);
    axi(1'b0, 32'h0000_0010, 32'h0, rd, rs);
    chk("resp", {30'h0, rssa_pkg::RSSA_RESP_ERR}, {30'h0, rs});
  endtask : t_regs
  // equal, larger and nibble-larger accumulator against the literal
  task automatic t_sub_lit;
    logic [15:0] cs [3] = '{16'h0505, 16'h0605, 16'h1f20};
    logic [7:0] w, k, e;
    foreach (cs[i]) begin
      w = cs[i][15:8];
      k = cs[i][7:0];
      e = k - w;
      axi(1'b1, rssa_pkg::RSSA_ADDR_ACC, {24'h0, w}, rd, rs);
      put(rssa_pkg::RSSA_OP_SUB_LIT, 7'h00, 1'b0, k);
      idle();
      chk("acc", {24'h0, e}, {24'h0, o_acc});
      chk("flags", {29'h0, w <= k, w[3:0] <= k[3:0], e == 8'h00}, {29'h0, o_flags});
    end
  endtask : t_sub_lit
  // back to back: the borrow must see the carry left by the first subtract
  task automatic t_sub_file;
    fm.mem[3] = 8'h10;
    fm.mem[4] = 8'h20;
    axi(1'b1, rssa_pkg::RSSA_ADDR_ACC, 32'h0000_0020, rd, rs);
    put(rssa_pkg::RSSA_OP_SUB_FILE, 7'h03, 1'b0, 8'h00);
    put(rssa_pkg::RSSA_OP_SUB_FILE_B, 7'h04, 1'b1, 8'h00);
    idle();
    chk("acc", 32'h0000_00f0, {24'h0, o_acc});
    chk("flags", 32'h0, {29'h0, o_flags});
    idle();
    chk("file", 32'h0000_2f10, {16'h0, fm.mem[4], fm.mem[3]});
  endtask : t_sub_file
  // a zero rotate result must leave the zero flag alone
  task automatic t_rotate;
    fm.mem[6] = 8'ha5;
    fm.mem[7] = 8'h01;
    put(rssa_pkg::RSSA_OP_ROT_RIGHT, 7'h07, 1'b0, 8'h00);
    idle();
    chk("rot", 32'h0000_0004, {21'h0, o_acc, o_flags});
    put(rssa_pkg::RSSA_OP_ROT_RIGHT, 7'h06, 1'b1, 8'h00);
    idle();
    idle();
    chk("rot file", 32'h0000_d200, {16'h0, fm.mem[6], o_acc});
  endtask : t_rotate
  task automatic t_sleep;
    put(rssa_pkg::RSSA_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    idle();
    chk("pd to", 32'h1, {30'h0, o_powerdown_status_bit, o_timeout_status_bit});
    chk("wdt", 32'h0001_0000, {15'h0, o_wdt_clear, o_watchdog_counter_load,
        o_wdt_prescaler_load});
    chk("halt", 32'h3, {30'h0, o_osc_stop, o_halted});
    put(rssa_pkg::RSSA_OP_SUB_LIT, 7'h00, 1'b0, 8'h55);
    idle();
    chk("asleep", 32'h0, {23'h0, o_wdt_clear, o_acc});
    axi(1'b0, rssa_pkg::RSSA_ADDR_STATUS, 32'h0, rd, rs);
    chk("status", 32'h0000_0031, rd);
    @(posedge i_core_clk);
    i_wake <= 1'b1;
    @(posedge i_core_clk);
    i_wake <= 1'b0;
    idle();
    chk("wake pin", 32'h0, {31'h0, o_halted});
    put(rssa_pkg::RSSA_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    idle();
    axi(1'b1, rssa_pkg::RSSA_ADDR_CTRL, 32'h0000_0001, rd, rs);
    idle();
    chk("wake reg", 32'h0, {31'h0, o_halted});
  endtask : t_sleep
  // reset for 16 cycles, then leave the synchroniser its edges before any request
  initial begin
    i_rst_b = 1'b0;
    i_valid = 1'b0;
    i_wake = 1'b0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
    {i_awaddr, i_wdata, i_araddr} = 96'h0;
    req_op = rssa_pkg::RSSA_OP_NONE;
    {req_fa, req_dst, req_lit} = 16'h0;
    fm.mem[0] = 8'h00;
    repeat (16) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    t_regs();
    t_sub_lit();
    t_sub_file();
    t_rotate();
    t_sleep();
    final_report();
  end
endmodule : tb_rotate_subtract_sleep_alu
bind rssa_alu rssa_alu_checker chk_i (
  .i_core_clk, .i_rst_b, .i_valid, .i_req, .o_wb, .o_acc, .o_flags, .o_powerdown_status_bit,
  .o_timeout_status_bit, .o_wdt_clear, .o_watchdog_counter_load, .o_wdt_prescaler_load,
  .o_osc_stop, .o_halted
);

// ---- src/rssa_alu.sv ----
/*
  rotate/subtract/sleep alu: executes one instruction per instruction
  clock, holds the accumulator, the arithmetic flags, the power-down and
  time-out status bits, and drives watchdog clear and oscillator stop.
  assumes the core decode presents one request per cycle with the file
  operand already read, and writes back file results from o_wb.
*/
// Summary of operation
// RULE1: rotate right puts old carry into bit 7 and old bit 0 into carry, changing only carry.
// RULE2: file-register results go to the accumulator when dest is 0, else back to the file.
// RULE3: subtract-from-literal writes literal minus accumulator into the accumulator.
// RULE4: literal subtract sets carry and digit carry unless the accumulator exceeds, and sets zero.
// RULE5: file subtract computes file minus accumulator with the same carry, digit carry, zero.
// RULE6: subtract with borrow also takes away the inverted carry and routes by dest.
// RULE7: sleep clears the power-down bit and sets the time-out bit.
// RULE8: sleep clears the watchdog counter and its prescaler.
// RULE9: after sleep the core halts with its oscillator stopped until woken.
// RULE10: zero is set when an 8-bit subtract result is zero, and each operation takes one cycle.
`timescale 1ns/1ps
module rssa_alu (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // instruction request
  input wire logic i_valid,
  input wire rssa_pkg::rssa_req_t i_req,
  input wire logic i_wake,
  // write back and status
  output rssa_pkg::rssa_wb_t o_wb,
  output logic [7:0] o_acc,
  output rssa_pkg::rssa_flags_t o_flags,
  output logic o_powerdown_status_bit,
  output logic o_timeout_status_bit,
  // watchdog and oscillator
  output logic o_wdt_clear,
  output logic [7:0] o_watchdog_counter_load,
  output logic [7:0] o_wdt_prescaler_load,
  output logic o_osc_stop,
  output logic o_halted,
  // axi4-lite slave
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    rssa_pkg::rssa_state_t st;
    logic [7:0] acc;
    rssa_pkg::rssa_flags_t flags;
    logic pd_b;
    logic to_b;
    logic wdt_clear;
    rssa_pkg::rssa_wb_t wb;
    logic aw_held;
    logic [31:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rssa_state_all_t;
  // status bits reset high as after power-on; other reset causes are handled outside
  localparam rssa_state_all_t S_RST = '{
    st: rssa_pkg::RSSA_ST_RUN,
    acc: rssa_pkg::RSSA_ACC_RST,
    pd_b: 1'b1,
    to_b: 1'b1,
    default: '0
  };

  rssa_state_all_t s_r;
  rssa_state_all_t s_nxt;
  logic rst_core_b;
  logic [7:0] sub_a;
  logic [7:0] sub_b;
  logic sub_borrow;
  logic [7:0] sub_diff;
  logic sub_carry;
  logic sub_dc;

  logic [1:0] rst_sync_r;
  // reset release through two flops, kept apart from the state as it resets on the raw pin
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_core_b = rst_sync_r[1];

  // ---------------------------------------------------------------
  // shared subtractor
  // ---------------------------------------------------------------
  // one subtractor serves all three subtracts; the literal subtract swaps the minuend, the borrow subtract adds a borrow
  always_comb begin
    sub_a = i_req.file_data;
    sub_b = s_r.acc;
    sub_borrow = 1'b0;
    if (i_req.op == rssa_pkg::RSSA_OP_SUB_LIT) begin
      sub_a = i_req.literal; // see RULE3
    end
    if (i_req.op == rssa_pkg::RSSA_OP_SUB_FILE_B) begin
      sub_borrow = ~s_r.flags.carry; // see RULE6
    end
  end

  rssa_sub8 u_sub (
    .i_a(sub_a),
    .i_b(sub_b),
    .i_borrow(sub_borrow),
    .o_diff(sub_diff),
    .o_carry(sub_carry),
    .o_dc(sub_dc)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] res;
    logic bus_wr;
    res = 8'h00;
    bus_wr = 1'b0;
    s_nxt = s_r;
    s_nxt.wdt_clear = 1'b0;
    s_nxt.wb.acc_we = 1'b0;
    s_nxt.wb.file_we = 1'b0;
    // instruction execution, one cycle each
    case (s_r.st)
      rssa_pkg::RSSA_ST_RUN: begin
        if (i_valid) begin
          case (i_req.op)
            rssa_pkg::RSSA_OP_ROT_RIGHT: begin
              res = {s_r.flags.carry, i_req.file_data[rssa_pkg::RSSA_MSB:1]}; // see RULE1
              s_nxt.flags.carry = i_req.file_data[0]; // see RULE1
            end
            rssa_pkg::RSSA_OP_SUB_LIT, rssa_pkg::RSSA_OP_SUB_FILE,
            rssa_pkg::RSSA_OP_SUB_FILE_B: begin
              res = sub_diff; // see RULE5
              s_nxt.flags.carry = sub_carry; // see RULE4
              s_nxt.flags.digit_carry_flag = sub_dc; // see RULE4
              s_nxt.flags.zero = (sub_diff == 8'h00); // see RULE10
            end
            rssa_pkg::RSSA_OP_SLEEP: begin
              s_nxt.pd_b = 1'b0; // see RULE7
              s_nxt.to_b = 1'b1; // see RULE7
              s_nxt.wdt_clear = 1'b1; // see RULE8
              s_nxt.st = rssa_pkg::RSSA_ST_SLEEP; // see RULE9
            end
            default: begin
            end
          endcase
          // destination routing; literal subtract always lands in the accumulator
          case (i_req.op)
            rssa_pkg::RSSA_OP_SUB_LIT: begin
              s_nxt.acc = res; // see RULE3
              s_nxt.wb.acc_we = 1'b1;
            end
            rssa_pkg::RSSA_OP_ROT_RIGHT, rssa_pkg::RSSA_OP_SUB_FILE,
            rssa_pkg::RSSA_OP_SUB_FILE_B: begin
              if (i_req.dest_file) begin
                s_nxt.wb.file_we = 1'b1; // see RULE2
              end else begin
                s_nxt.acc = res; // see RULE2
                s_nxt.wb.acc_we = 1'b1;
              end
            end
            default: begin
            end
          endcase
          s_nxt.wb.result = res;
          s_nxt.wb.file_addr = i_req.file_addr;
        end
      end
      rssa_pkg::RSSA_ST_SLEEP: begin
        // requests are ignored while halted; wake comes from outside
        if (i_wake) begin
          s_nxt.st = rssa_pkg::RSSA_ST_RUN; // see RULE9
        end
      end
      default: begin
        s_nxt.st = rssa_pkg::RSSA_ST_RUN;
      end
    endcase

    // axi4-lite write: address and data taken in either order
    if (!s_r.aw_held && i_awvalid) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = i_awaddr;
    end
    if (!s_r.w_held && i_wvalid) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = i_wdata;
      s_nxt.wstrb = i_wstrb;
    end
    if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    bus_wr = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    if (bus_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rssa_pkg::RSSA_RESP_OK;
      if (s_r.awaddr == rssa_pkg::RSSA_ADDR_ACC) begin
        // software writes lose to a same-cycle instruction write
        if (s_r.wstrb[0] && !s_nxt.wb.acc_we) begin
          s_nxt.acc = s_r.wdata[7:0];
        end
      end else if (s_r.awaddr == rssa_pkg::RSSA_ADDR_CTRL) begin
        if (s_r.wstrb[0] && s_r.wdata[rssa_pkg::RSSA_CTRL_WAKE]) begin
          s_nxt.st = rssa_pkg::RSSA_ST_RUN;
        end
      end else if (s_r.awaddr != rssa_pkg::RSSA_ADDR_STATUS) begin
        s_nxt.bresp = rssa_pkg::RSSA_RESP_ERR;
      end
    end

    // axi4-lite read
    if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (!s_r.rvalid && i_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = rssa_pkg::RSSA_RESP_OK;
      s_nxt.rdata = 32'h0000_0000;
      case (i_araddr)
        rssa_pkg::RSSA_ADDR_ACC: s_nxt.rdata[7:0] = s_r.acc;
        rssa_pkg::RSSA_ADDR_STATUS: begin
          s_nxt.rdata[rssa_pkg::RSSA_ST_C] = s_r.flags.carry;
          s_nxt.rdata[rssa_pkg::RSSA_ST_DC] = s_r.flags.digit_carry_flag;
          s_nxt.rdata[rssa_pkg::RSSA_ST_Z] = s_r.flags.zero;
          s_nxt.rdata[rssa_pkg::RSSA_ST_PD] = s_r.pd_b;
          s_nxt.rdata[rssa_pkg::RSSA_ST_TO] = s_r.to_b;
          s_nxt.rdata[rssa_pkg::RSSA_ST_SLP] = (s_r.st == rssa_pkg::RSSA_ST_SLEEP);
        end
        rssa_pkg::RSSA_ADDR_CTRL: s_nxt.rdata = 32'h0000_0000;
        default: s_nxt.rresp = rssa_pkg::RSSA_RESP_ERR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // one register stage for the whole state, reset through the synchronised copy
  always_ff @(posedge i_core_clk or negedge rst_core_b) begin
    if (!rst_core_b) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_wb = s_r.wb;
  assign o_acc = s_r.acc;
  assign o_flags = s_r.flags;
  assign o_powerdown_status_bit = s_r.pd_b;
  assign o_timeout_status_bit = s_r.to_b;
  assign o_wdt_clear = s_r.wdt_clear; // see RULE8
  assign o_watchdog_counter_load = rssa_pkg::RSSA_WDT_CLR;
  assign o_wdt_prescaler_load = rssa_pkg::RSSA_PRE_CLR;
  assign o_osc_stop = (s_r.st == rssa_pkg::RSSA_ST_SLEEP); // see RULE9
  assign o_halted = (s_r.st == rssa_pkg::RSSA_ST_SLEEP);
  assign o_awready = !s_r.aw_held;
  assign o_wready = !s_r.w_held;
  assign o_bvalid = s_r.bvalid;
  assign o_bresp = s_r.bresp;
  assign o_arready = !s_r.rvalid;
  assign o_rvalid = s_r.rvalid;
  assign o_rdata = s_r.rdata;
  assign o_rresp = s_r.rresp;
endmodule : rssa_alu

// ---- src/rssa_pkg.sv ----
/*
  package for the rotate/subtract/sleep alu: opcode encoding, flag layout,
  reset values and register offsets.
  assumes an axi4-lite master with 32-bit data and aligned word accesses.
*/
package rssa_pkg;
  // ---------------------------------------------------------------
  // operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RSSA_OP_NONE = 3'h0,
    RSSA_OP_ROT_RIGHT = 3'h1, // rotate_right_carry_op
    RSSA_OP_SUB_LIT = 3'h2, // sub_acc_from_literal_op
    RSSA_OP_SUB_FILE = 3'h3, // sub_acc_from_file_op
    RSSA_OP_SUB_FILE_B = 3'h4, // sub_acc_from_file_borrow_op
    RSSA_OP_SLEEP = 3'h5
  } rssa_op_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } rssa_flags_t;

  typedef struct packed {
    rssa_op_t op;
    logic [6:0] file_addr;
    logic dest_file;
    logic [7:0] literal;
    logic [7:0] file_data;
  } rssa_req_t;

  typedef struct packed {
    logic acc_we;
    logic file_we;
    logic [6:0] file_addr;
    logic [7:0] result;
  } rssa_wb_t;

  typedef enum logic [1:0] {
    RSSA_ST_RUN = 2'b01,
    RSSA_ST_SLEEP = 2'b10
  } rssa_state_t;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam logic [7:0] RSSA_ACC_RST = 8'h00;
  localparam logic [7:0] RSSA_WDT_CLR = 8'h00;
  localparam logic [7:0] RSSA_PRE_CLR = 8'h00;
  localparam int RSSA_MSB = 7;
  localparam int RSSA_NIB = 4;
  localparam logic [31:0] RSSA_ADDR_ACC = 32'h0000_0000;
  localparam logic [31:0] RSSA_ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] RSSA_ADDR_CTRL = 32'h0000_0008;
  localparam logic [1:0] RSSA_RESP_OK = 2'h0;
  localparam logic [1:0] RSSA_RESP_ERR = 2'h2;
  localparam int RSSA_ST_C = 0;
  localparam int RSSA_ST_DC = 1;
  localparam int RSSA_ST_Z = 2;
  localparam int RSSA_ST_PD = 3;
  localparam int RSSA_ST_TO = 4;
  localparam int RSSA_ST_SLP = 5;
  localparam int RSSA_CTRL_WAKE = 0;
endpackage : rssa_pkg

// ---- src/rssa_sub8.sv ----
/*
  8-bit subtractor a - b - borrow with carry (not borrow) and digit carry.
  assumes nothing; purely combinational.
*/
`timescale 1ns/1ps
module rssa_sub8 (
  // operands
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_borrow,
  // result
  output logic [7:0] o_diff,
  output logic o_carry,
  output logic o_dc
);
  logic [8:0] sum;
  logic [4:0] low;
  // two's complement: a + ~b + carry_in, carry_in is the inverted borrow
  always_comb begin
    sum = {1'b0, i_a} + {1'b0, ~i_b} + {8'h00, ~i_borrow};
    low = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]} + {4'h0, ~i_borrow};
    o_diff = sum[7:0];
    o_carry = sum[8];
    o_dc = low[4];
  end
endmodule : rssa_sub8
